// ==== hdl/elp_top.sv ====
// exception arbitration, break handling and low-power sequencing
//
// Summary of operation
// RL1 - interrupt entry requests stacking and sets the interrupt mask
// RL2 - return-from-interrupt requests unstacking and restores the mask
// RL3 - requests latched and arbitrated at entry; vector code sent to core
// RL4 - latched interrupt holds until its vector is taken or mask cleared
// RL5 - hardware interrupts only start at an instruction boundary
// RL6 - take request only when mask clear and its enable set
// RL7 - lowest-numbered pending request has highest priority and wins
// RL8 - request pending after return is taken before prefetched opcode runs
// RL9 - high index register never stacked; routines save it themselves
// RL10 - software interrupt is taken regardless of the mask
// RL11 - software interrupt stacks pc, hardware stacks pc minus one
// RL12 - reset sources override everything and skip arbitration
// RL13 - break forces entry through the software-interrupt vector
// RL14 - during break flags are protected unless clear-enable bit is set
// RL15 - flag cleared in break stays cleared afterwards
// RL16 - two-step flags stay protected in break; later second step clears
// RL17 - wait and stop clear mask and stop the core clock
// RL18 - wait keeps peripherals clocked; enabled request stacks next cycle
// RL19 - reset or break ends wait; break in wait sets break-wait flag
// RL20 - watchdog runs, also in wait, while its disable bit is zero
// RL21 - stop holds recovery counter reset, gates clocks; request ends it
// RL22 - recovery lasts 4096 cycles, or 32 with short-recovery bit set
// RL23 - break-wait flag cleared by writing zero and by any reset
// RL24 - clear-enable bit is read/write; one opens clearing during break
`timescale 1ns/100ps
module elp_top (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]                      avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [31:0]                     avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic [31:0]                          avs_readdata,
  output logic                                 avs_waitrequest,
  // core side
  input  wire elp_pkg::elp_core_req_t          core_req_i,
  output elp_pkg::elp_core_ctl_t               core_ctl_o,
  // requests from modules and break logic
  input  wire logic [elp_pkg::NUM_IRQ-1:0]     irq_req_i,
  input  wire logic [elp_pkg::NUM_IRQ-1:0]     irq_en_i,
  input  wire logic                            brk_irq_i,
  input  wire logic                            reset_src_i,
  // configuration bits
  input  wire logic                            watchdog_disable_bit_i,
  input  wire logic                            short_recovery_bit_i,
  // protected peripheral flags
  input  wire logic [elp_pkg::NUM_FLAGS-1:0]   flag_set_i,
  input  wire logic [elp_pkg::NUM_FLAGS-1:0]   flag_step1_i,
  input  wire logic [elp_pkg::NUM_FLAGS-1:0]   flag_step2_i,
  output logic [elp_pkg::NUM_FLAGS-1:0]        flag_o,
  // clocks and break state
  output elp_pkg::elp_clk_ctl_t                clk_ctl_o,
  output logic                                 break_state_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    elp_pkg::elp_mode_t mode;
    logic               i_mask;
    logic [3:0]         vec;
    logic               pc_dec;
    logic               unstack;
    logic               cancel;
    logic               reset_taken;
    logic               after_rti;
    logic               brk_state;
    logic               bw;
    logic               break_clear_enable_bit;
    logic               wdog;
    logic               ack;
    logic [31:0]        rdata;
  } elp_state_t;

  elp_state_t                    s_reg;
  elp_state_t                    s_next;
  logic [elp_pkg::NUM_IRQ-1:0]   pend_w;
  logic                          any_pend_w;
  logic [3:0]                    win_w;
  logic                          rec_done_w;
  logic                          rec_hold_w;
  logic                          wr_ok_w;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  always_comb begin
    pend_w     = irq_req_i & irq_en_i; // RL6
    any_pend_w = |pend_w;
    win_w      = elp_pkg::VEC_NONE;
    // descending scan so the lowest index is left standing
    for (int i = elp_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (pend_w[i]) begin
        win_w = 4'(i); // RL7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and register file

  always_comb begin
    s_next             = s_reg;
    s_next.unstack     = 1'b0;
    s_next.cancel      = 1'b0;
    s_next.reset_taken = 1'b0;
    s_next.wdog        = !watchdog_disable_bit_i; // RL20
    wr_ok_w            = avs_write && s_reg.ack && avs_byteenable[0];

    case (s_reg.mode)
      elp_pkg::MODE_RUN: begin
        if (core_req_i.i_set) begin
          s_next.i_mask = 1'b1;
        end
        if (core_req_i.i_clr) begin
          s_next.i_mask = 1'b0;
        end
        if (core_req_i.return_from_interrupt_instr) begin
          s_next.unstack   = 1'b1; // RL2
          s_next.i_mask    = core_req_i.rti_i_val; // RL2
          s_next.after_rti = 1'b1;
          if (s_reg.brk_state) begin
            s_next.brk_state = 1'b0;
          end
        end else if (core_req_i.wait_exec) begin
          s_next.i_mask = 1'b0; // RL17
          s_next.mode   = elp_pkg::MODE_WAIT;
        end else if (core_req_i.stop_exec) begin
          s_next.i_mask = 1'b0; // RL17
          s_next.mode   = elp_pkg::MODE_STOP;
        end else if (core_req_i.boundary) begin // RL5
          s_next.after_rti = 1'b0;
          if (brk_irq_i) begin
            s_next.vec       = elp_pkg::VEC_SWI; // RL13
            s_next.pc_dec    = 1'b1;
            s_next.brk_state = 1'b1;
            s_next.i_mask    = 1'b1;
            s_next.mode      = elp_pkg::MODE_STACK;
          end else if (core_req_i.software_interrupt_instr) begin
            s_next.vec    = elp_pkg::VEC_SWI; // RL10
            s_next.pc_dec = 1'b0; // RL11
            s_next.i_mask = 1'b1;
            s_next.mode   = elp_pkg::MODE_STACK;
          end else if (any_pend_w && !s_reg.i_mask) begin // RL6
            s_next.vec    = win_w; // RL3
            s_next.pc_dec = 1'b1; // RL11
            s_next.i_mask = 1'b1; // RL1
            s_next.cancel = s_reg.after_rti; // RL8
            s_next.mode   = elp_pkg::MODE_STACK;
          end
        end
      end
      elp_pkg::MODE_STACK: begin
        // vector frozen here, nothing re-arbitrates until release
        if (core_req_i.vec_taken || core_req_i.i_clr) begin // RL4
          s_next.mode = elp_pkg::MODE_RUN;
          if (core_req_i.i_clr) begin
            s_next.i_mask = 1'b0;
          end
        end
      end
      elp_pkg::MODE_WAIT: begin
        if (brk_irq_i) begin
          s_next.bw        = 1'b1; // RL19
          s_next.vec       = elp_pkg::VEC_SWI; // RL13
          s_next.pc_dec    = 1'b1;
          s_next.brk_state = 1'b1;
          s_next.i_mask    = 1'b1;
          s_next.mode      = elp_pkg::MODE_STACK;
        end else if (any_pend_w && !s_reg.i_mask) begin
          s_next.vec    = win_w; // RL18
          s_next.pc_dec = 1'b1;
          s_next.i_mask = 1'b1; // RL1
          s_next.mode   = elp_pkg::MODE_STACK; // RL18
        end
      end
      elp_pkg::MODE_STOP: begin
        // break logic is asleep in stop, only enabled module requests or a reset source wake
        if (any_pend_w) begin
          s_next.mode = elp_pkg::MODE_RECOVER; // RL21
        end
      end
      elp_pkg::MODE_RECOVER: begin
        if (rec_done_w) begin
          s_next.vec    = win_w; // RL21
          s_next.pc_dec = 1'b1;
          s_next.i_mask = 1'b1;
          s_next.mode   = elp_pkg::MODE_STACK;
        end
      end
      default: begin
        s_next.mode = elp_pkg::MODE_RUN;
      end
    endcase

    // bus slave: one wait state, data registered on the first cycle
    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      s_next.rdata = '0;
      if (avs_address == elp_pkg::OFF_BREAK_STATUS) begin
        s_next.rdata[elp_pkg::BW_POS] = s_reg.bw;
      end else if (avs_address == elp_pkg::OFF_BREAK_CTRL) begin
        s_next.rdata[elp_pkg::BREAK_CLEAR_ENABLE_BIT_POS] = s_reg.break_clear_enable_bit; // RL24
      end else if (avs_address == elp_pkg::OFF_STATE) begin
        s_next.rdata[elp_pkg::ST_MODE +: 3]               = s_reg.mode;
        s_next.rdata[elp_pkg::ST_VEC +: 4]                = s_reg.vec;
        s_next.rdata[elp_pkg::ST_IMASK]                   = s_reg.i_mask;
        s_next.rdata[elp_pkg::ST_BRK]                     = s_reg.brk_state;
        s_next.rdata[elp_pkg::ST_FLAGS +: elp_pkg::NUM_FLAGS] = flag_o;
      end
    end
    if (wr_ok_w && avs_address == elp_pkg::OFF_BREAK_CTRL) begin
      s_next.break_clear_enable_bit = avs_writedata[elp_pkg::BREAK_CLEAR_ENABLE_BIT_POS]; // RL24
    end
    // a write of zero clears, but a break that lands now keeps the flag
    if (wr_ok_w && avs_address == elp_pkg::OFF_BREAK_STATUS &&
        !avs_writedata[elp_pkg::BW_POS] &&
        !(s_reg.mode == elp_pkg::MODE_WAIT && brk_irq_i)) begin
      s_next.bw = 1'b0; // RL23
    end

    // any reset source beats every other transition
    if (reset_src_i) begin
      s_next.mode        = elp_pkg::MODE_RUN; // RL12
      s_next.vec         = elp_pkg::VEC_RESET; // RL12
      s_next.i_mask      = elp_pkg::IMASK_RST;
      s_next.reset_taken = 1'b1;
      s_next.after_rti   = 1'b0;
      s_next.brk_state   = 1'b0;
      s_next.bw          = elp_pkg::BW_RST; // RL23
      s_next.break_clear_enable_bit        = elp_pkg::BREAK_CLEAR_ENABLE_BIT_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_reg        <= '0;
      s_reg.mode   <= elp_pkg::MODE_RUN;
      s_reg.i_mask <= elp_pkg::IMASK_RST;
      s_reg.vec    <= elp_pkg::VEC_RESET;
      s_reg.bw     <= elp_pkg::BW_RST; // RL23
      s_reg.break_clear_enable_bit   <= elp_pkg::BREAK_CLEAR_ENABLE_BIT_RST;
      s_reg.wdog   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop recovery

  assign rec_hold_w = (s_reg.mode != elp_pkg::MODE_RECOVER); // RL21

  elp_recovery_counter u_rec (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .hold_i  (rec_hold_w),
    .short_i (short_recovery_bit_i),
    .done_o  (rec_done_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flag protection during break

  // first two flags clear in one step, the others need two
  for (genvar g = 0; g < elp_pkg::NUM_FLAGS; g++) begin : g_flag
    elp_flag_guard #(
      .TWO_STEP (g >= 2)
    ) u_guard (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .set_i      (flag_set_i[g]),
      .step1_i    (flag_step1_i[g]),
      .step2_i    (flag_step2_i[g]),
      .break_i    (s_reg.brk_state),
      .clear_en_i (s_reg.break_clear_enable_bit),
      .flag_o     (flag_o[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
  assign avs_readdata    = s_reg.rdata;

  always_comb begin
    core_ctl_o.stack_req       = (s_reg.mode == elp_pkg::MODE_STACK); // RL1
    core_ctl_o.stack_pc_dec    = s_reg.pc_dec; // RL11
    core_ctl_o.stack_h         = 1'b0; // RL9
    core_ctl_o.unstack_req     = s_reg.unstack;
    core_ctl_o.cancel_prefetch = s_reg.cancel; // RL8
    core_ctl_o.reset_taken     = s_reg.reset_taken;
    core_ctl_o.vector_sel      = s_reg.vec; // RL3
    core_ctl_o.i_mask          = s_reg.i_mask;
  end

  always_comb begin
    clk_ctl_o.cpu_clk_en    = (s_reg.mode == elp_pkg::MODE_RUN) ||
                              (s_reg.mode == elp_pkg::MODE_STACK); // RL17
    clk_ctl_o.periph_clk_en = (s_reg.mode != elp_pkg::MODE_STOP) &&
                              (s_reg.mode != elp_pkg::MODE_RECOVER); // RL18
    clk_ctl_o.base_clk_en   = (s_reg.mode != elp_pkg::MODE_STOP); // RL21
    clk_ctl_o.xtal_clk_en   = (s_reg.mode != elp_pkg::MODE_STOP); // RL21
    clk_ctl_o.watchdog_run  = s_reg.wdog; // RL20
  end

  assign break_state_o = s_reg.brk_state;

endmodule : elp_top

// ==== hdl/elp_pkg.sv ====
// shared constants and types of the exception and low-power control unit
package elp_pkg;

  localparam int NUM_IRQ   = 8;
  localparam int NUM_FLAGS = 4;

  // register byte offsets
  localparam logic [3:0] OFF_BREAK_STATUS = 4'h0;
  localparam logic [3:0] OFF_BREAK_CTRL   = 4'h4;
  localparam logic [3:0] OFF_STATE        = 4'h8;

  // field positions
  localparam int BW_POS    = 0;
  localparam int BREAK_CLEAR_ENABLE_BIT_POS  = 0;
  localparam int ST_MODE   = 0;
  localparam int ST_VEC    = 4;
  localparam int ST_IMASK  = 8;
  localparam int ST_BRK    = 9;
  localparam int ST_FLAGS  = 12;

  // reset values
  localparam logic BW_RST    = 1'b0;
  localparam logic BREAK_CLEAR_ENABLE_BIT_RST  = 1'b0;
  localparam logic IMASK_RST = 1'b1;

  // vector codes handed to the core
  localparam logic [3:0] VEC_RESET = 4'hf;
  localparam logic [3:0] VEC_SWI   = 4'he;
  localparam logic [3:0] VEC_NONE  = 4'h0;

  // stop recovery in crystal clock cycles
  localparam logic [12:0] STOP_LONG_CYC  = 13'h1000;
  localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_STACK,
    MODE_WAIT,
    MODE_STOP,
    MODE_RECOVER
  } elp_mode_t;

  // events from the core, each a one-cycle pulse except rti_i_val
  typedef struct packed {
    logic boundary;
    logic software_interrupt_instr;
    logic return_from_interrupt_instr;
    logic rti_i_val;
    logic wait_exec;
    logic stop_exec;
    logic i_set;
    logic i_clr;
    logic vec_taken;
  } elp_core_req_t;

  // controls towards the core
  typedef struct packed {
    logic       stack_req;
    logic       stack_pc_dec;
    logic       stack_h;
    logic       unstack_req;
    logic       cancel_prefetch;
    logic       reset_taken;
    logic [3:0] vector_sel;
    logic       i_mask;
  } elp_core_ctl_t;

  // clock gating controls
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic base_clk_en;
    logic xtal_clk_en;
    logic watchdog_run;
  } elp_clk_ctl_t;

endpackage : elp_pkg

// ==== hdl/elp_flag_guard.sv ====
// one peripheral status flag with break-mode clear protection
`timescale 1ns/100ps
module elp_flag_guard #(
  parameter bit TWO_STEP = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic step1_i,
  input  wire logic step2_i,
  input  wire logic break_i,
  input  wire logic clear_en_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
    logic armed;
  } elp_guard_t;

  elp_guard_t g_reg;
  elp_guard_t g_next;
  logic       open_w;
  logic       clr_w;

  always_comb begin
    g_next = g_reg;
    open_w = !break_i || clear_en_i; // RL14 RL24
    // an arm made before break survives it; a protected break cannot arm
    if (step1_i && open_w) begin
      g_next.armed = 1'b1; // RL16
    end
    clr_w = step2_i && open_w && (!TWO_STEP || g_reg.armed || (step1_i && open_w)); // RL16
    if (clr_w) begin
      g_next.flag  = 1'b0; // RL15
      g_next.armed = 1'b0;
    end
    if (set_i) begin
      g_next.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      g_reg <= '0;
    end else begin
      g_reg <= g_next;
    end
  end

  assign flag_o = g_reg.flag;

endmodule : elp_flag_guard

// ==== hdl/elp_recovery_counter.sv ====
// stop-mode recovery delay counter
`timescale 1ns/100ps
module elp_recovery_counter (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic hold_i,
  input  wire logic short_i,
  output logic      done_o
);

  typedef struct packed {
    logic [12:0] cnt;
    logic        done;
  } elp_rec_t;

  elp_rec_t    r_reg;
  elp_rec_t    r_next;
  logic [12:0] limit_w;

  always_comb begin
    r_next  = r_reg;
    limit_w = short_i ? elp_pkg::STOP_SHORT_CYC : elp_pkg::STOP_LONG_CYC; // RL22
    if (hold_i) begin
      r_next.cnt  = '0; // RL21
      r_next.done = 1'b0;
    end else if (!r_reg.done) begin
      r_next.cnt  = r_reg.cnt + 13'h0001;
      r_next.done = (r_next.cnt == limit_w); // RL22
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_o = r_reg.done;

endmodule : elp_recovery_counter

// ==== bench/elp_core_model.sv ====
// behavioural processor core answering stacking requests
`timescale 1ns/100ps
module elp_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       stack_req_i,
  input  wire logic [3:0] delay_i,
  output logic            vec_taken_o
);
  logic [3:0] cnt_reg;

  // stack_h is never consulted: the routine keeps the index register itself
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg     <= 4'h0;
      vec_taken_o <= 1'b0;
    end else begin
      vec_taken_o <= 1'b0;
      if (!stack_req_i || vec_taken_o) begin
        cnt_reg <= 4'h0;
      end else if (delay_i != 4'hf && cnt_reg >= delay_i) begin
        // 4'hf never answers, so an entry can be held open
        vec_taken_o <= 1'b1;
        cnt_reg     <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : elp_core_model

// ==== bench/elp_top_props.sv ====
// concurrent checks on the exception and low-power control ports
`timescale 1ns/100ps
module elp_top_props (
  input wire logic                        clk_i,
  input wire logic                        rst_n_i,
  input wire elp_pkg::elp_core_req_t      core_req_i,
  input wire elp_pkg::elp_core_ctl_t      core_ctl_o,
  input wire logic [elp_pkg::NUM_IRQ-1:0] irq_req_i,
  input wire logic [elp_pkg::NUM_IRQ-1:0] irq_en_i,
  input wire logic                        brk_irq_i,
  input wire logic                        reset_src_i,
  input wire logic                        watchdog_disable_bit_i,
  input wire elp_pkg::elp_clk_ctl_t       clk_ctl_o,
  input wire logic                        break_state_o
);
  logic [3:0] win;
  logic       run;
  logic       calm;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  always_comb begin
    win = elp_pkg::VEC_NONE;
    for (int i = elp_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req_i[i] && irq_en_i[i]) begin
        win = 4'(i);
      end
    end
  end
  // run mode as seen from outside: core clocked, nothing being stacked
  assign run  = clk_ctl_o.cpu_clk_en && !core_ctl_o.stack_req;
  assign calm = run && !reset_src_i && !core_req_i.return_from_interrupt_instr && !core_req_i.wait_exec && !core_req_i.stop_exec;
  ////////////////////////////////////////
  property p_hw_take;
    core_req_i.boundary && calm && !brk_irq_i && !core_req_i.software_interrupt_instr && !core_req_i.i_set && !core_req_i.i_clr
      && !core_ctl_o.i_mask && |(irq_req_i & irq_en_i) |=> core_ctl_o.stack_req && core_ctl_o.i_mask
      && core_ctl_o.stack_pc_dec && core_ctl_o.vector_sel == $past(win);
  endproperty
  a_hw_take: assert property (p_hw_take) else $error("bad hw entry");
  property p_soft;
    core_req_i.boundary && core_req_i.software_interrupt_instr && calm && !brk_irq_i |=> core_ctl_o.stack_req
      && core_ctl_o.vector_sel == elp_pkg::VEC_SWI && !core_ctl_o.stack_pc_dec;
  endproperty
  a_soft: assert property (p_soft) else $error("bad soft entry");
  property p_brk;
    core_req_i.boundary && brk_irq_i && calm |=> core_ctl_o.stack_req && break_state_o
      && core_ctl_o.vector_sel == elp_pkg::VEC_SWI;
  endproperty
  a_brk: assert property (p_brk) else $error("bad break entry");
  property p_hold;
    core_ctl_o.stack_req && !core_req_i.vec_taken && !core_req_i.i_clr && !reset_src_i
      |=> core_ctl_o.stack_req && $stable(core_ctl_o.vector_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("latched entry lost");
  property p_reset;
    reset_src_i |=> core_ctl_o.reset_taken && core_ctl_o.vector_sel == elp_pkg::VEC_RESET
      && core_ctl_o.i_mask && !core_ctl_o.stack_req;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset entry");
  property p_ret;
    core_req_i.return_from_interrupt_instr && run && !reset_src_i |=> core_ctl_o.unstack_req && core_ctl_o.i_mask == $past(core_req_i.rti_i_val);
  endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_wait;
    core_req_i.wait_exec && run && !core_req_i.return_from_interrupt_instr && !reset_src_i
      |=> !clk_ctl_o.cpu_clk_en && clk_ctl_o.periph_clk_en && !core_ctl_o.i_mask;
  endproperty
  a_wait: assert property (p_wait) else $error("bad wait entry");
  property p_stop;
    core_req_i.stop_exec && run && !core_req_i.return_from_interrupt_instr && !core_req_i.wait_exec && !reset_src_i
      |=> !clk_ctl_o.cpu_clk_en && !clk_ctl_o.base_clk_en && !clk_ctl_o.xtal_clk_en && !core_ctl_o.i_mask;
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop entry");
  property p_wdog;
    !watchdog_disable_bit_i |=> clk_ctl_o.watchdog_run;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog halted");
endmodule : elp_top_props

bind elp_top elp_top_props u_props (.clk_i, .rst_n_i, .core_req_i, .core_ctl_o, .irq_req_i, .irq_en_i, .brk_irq_i,
  .reset_src_i, .watchdog_disable_bit_i, .clk_ctl_o, .break_state_o);

// ==== bench/tb.sv ====
// self-checking bench for the exception and low-power control unit
`timescale 1ns/100ps
module tb;
  localparam logic [8:0] ev_b = 9'h100, ev_s = 9'h080, ev_r = 9'h040, ev_v = 9'h020;
  localparam logic [8:0] ev_w = 9'h010, ev_p = 9'h008, ev_c = 9'h002;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [8:0] creq = 9'h000;
  logic vt;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic brk = 1'b0;
  logic rsrc = 1'b0;
  logic wdd = 1'b0;
  logic short_recovery_bit = 1'b1;
  logic [3:0] fset = 4'h0;
  logic [3:0] fs1 = 4'h0;
  logic [3:0] fs2 = 4'h0;
  logic [3:0] flag;
  logic [3:0] dly = 4'h1;
  logic brk_st;
  logic [31:0] lfsr = 32'h075d73d0;
  logic [31:0] rd;
  elp_pkg::elp_core_ctl_t ctl;
  elp_pkg::elp_clk_ctl_t cc;
  int fails = 0;
  int cmp_count = 0;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  elp_top DUT (.clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .core_req_i(elp_pkg::elp_core_req_t'(creq | {8'h00, vt})), .core_ctl_o(ctl),
    .irq_req_i(irq_req), .irq_en_i(irq_en), .brk_irq_i(brk), .reset_src_i(rsrc), .watchdog_disable_bit_i(wdd),
    .short_recovery_bit_i(short_recovery_bit), .flag_set_i(fset), .flag_step1_i(fs1), .flag_step2_i(fs2), .flag_o(flag),
    .clk_ctl_o(cc), .break_state_o(brk_st));
  elp_core_model u_core (.clk_i, .rst_n_i, .stack_req_i(ctl.stack_req), .delay_i(dly), .vec_taken_o(vt));
  ////////////////////////////////////////
  function automatic logic [3:0] win(input logic [7:0] p);
    win = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (p[i]) win = 4'(i);
    end
  endfunction : win
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : ck
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_i);
    for (n = 0; n < 20 && avs_waitrequest !== 1'b0; n++) @(posedge clk_i);
    ck(avs_waitrequest, 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdck(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    ck(rd, e);
  endtask : rdck
  // one-cycle core event; on return the outputs show the reaction
  task automatic ev(input logic [8:0] v);
    creq <= v;
    @(posedge clk_i);
    creq <= 9'h000;
    @(posedge clk_i);
  endtask : ev
  task automatic fl(input logic [3:0] s, input logic [3:0] a, input logic [3:0] b);
    fset <= s;
    fs1 <= a;
    fs2 <= b;
    @(posedge clk_i);
    fset <= 4'h0;
    fs1 <= 4'h0;
    fs2 <= 4'h0;
    @(posedge clk_i);
  endtask : fl
  task automatic idle;
    int n;
    for (n = 0; n < 40 && ctl.stack_req !== 1'b0; n++) @(posedge clk_i);
    ck(ctl.stack_req, 1'b0);
  endtask : idle
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  initial begin
    #150000;
    fails++;
    final_report;
  end
  initial begin
    int n;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdck(elp_pkg::OFF_STATE, 32'h1f0);
    rdck(elp_pkg::OFF_BREAK_STATUS, 32'h0);
    rdck(4'hc, 32'h0);
    bus(1'b1, elp_pkg::OFF_BREAK_CTRL, 32'h1);
    rdck(elp_pkg::OFF_BREAK_CTRL, 32'h1);
    bus(1'b1, elp_pkg::OFF_BREAK_CTRL, 32'h0);
    for (int k = 0; k < 12; k++) begin
      lfsr = lfsr_next(lfsr);
      irq_req <= lfsr[7:0];
      irq_en <= lfsr[15:8];
      dly <= k[0] ? 4'h6 : 4'h0;
      ev(ev_c);
      ck(ctl.stack_req, 1'b0);
      ev(ev_b);
      ck(ctl.stack_req, |(lfsr[7:0] & lfsr[15:8]));
      if (ctl.stack_req === 1'b1) begin
        ck({ctl.vector_sel, ctl.stack_pc_dec, ctl.i_mask}, {win(lfsr[7:0] & lfsr[15:8]), 2'b11});
        irq_req <= 8'hff;
        irq_en <= 8'hff;
        idle;
        ev(ev_b);
        ck(ctl.stack_req, 1'b0);
      end
    end
    irq_req <= 8'h00;
    ev(ev_b | ev_s);
    ck({ctl.stack_req, ctl.vector_sel, ctl.stack_pc_dec}, {1'b1, elp_pkg::VEC_SWI, 1'b0});
    idle;
    irq_req <= 8'h10;
    irq_en <= 8'h10;
    ev(ev_r);
    ck({ctl.unstack_req, ctl.i_mask, ctl.stack_h}, 3'b100);
    ev(ev_b);
    ck({ctl.cancel_prefetch, ctl.stack_req, ctl.vector_sel}, {2'b11, 4'h4});
    idle;
    irq_req <= 8'h00;
    fl(4'hf, 4'hc, 4'h0);
    brk <= 1'b1;
    ev(ev_b);
    brk <= 1'b0;
    ck({ctl.vector_sel, brk_st, ctl.stack_pc_dec}, {elp_pkg::VEC_SWI, 2'b11});
    idle;
    fl(4'h0, 4'h0, 4'hf);
    ck(flag, 4'hf);
    bus(1'b1, elp_pkg::OFF_BREAK_CTRL, 32'h1);
    fl(4'h0, 4'h0, 4'h1);
    ck(flag, 4'he);
    bus(1'b1, elp_pkg::OFF_BREAK_CTRL, 32'h0);
    ev(ev_r | ev_v);
    fl(4'h0, 4'h0, 4'h4);
    ck({brk_st, flag}, 5'h0a);
    ev(ev_w);
    ck({cc.cpu_clk_en, cc.periph_clk_en, cc.watchdog_run, ctl.i_mask}, 4'b0110);
    wdd <= 1'b1;
    repeat (2) @(posedge clk_i);
    ck(cc.watchdog_run, 1'b0);
    wdd <= 1'b0;
    brk <= 1'b1;
    @(posedge clk_i);
    brk <= 1'b0;
    @(posedge clk_i);
    ck({ctl.stack_req, ctl.vector_sel}, {1'b1, elp_pkg::VEC_SWI});
    idle;
    rdck(elp_pkg::OFF_BREAK_STATUS, 32'h1);
    bus(1'b1, elp_pkg::OFF_BREAK_STATUS, 32'h1);
    rdck(elp_pkg::OFF_BREAK_STATUS, 32'h1);
    bus(1'b1, elp_pkg::OFF_BREAK_STATUS, 32'h0);
    rdck(elp_pkg::OFF_BREAK_STATUS, 32'h0);
    ev(ev_r | ev_v);
    ev(ev_w);
    irq_req <= 8'h04;
    irq_en <= 8'h04;
    repeat (2) @(posedge clk_i);
    ck({ctl.stack_req, ctl.vector_sel}, {1'b1, 4'h2});
    idle;
    irq_req <= 8'h00;
    for (int s = 1; s >= 0; s--) begin
      short_recovery_bit <= s[0];
      ev(ev_p);
      ck(cc, 5'h01);
      irq_req <= 8'h02;
      irq_en <= 8'h02;
      for (n = 0; n < 5000 && ctl.stack_req !== 1'b1; n++) @(posedge clk_i);
      ck(n >= (s ? 32 : 4096) && n <= (s ? 36 : 4100), 1'b1);
      idle;
      irq_req <= 8'h00;
    end
    bus(1'b1, elp_pkg::OFF_BREAK_CTRL, 32'h1);
    dly <= 4'hf;
    irq_req <= 8'h01;
    irq_en <= 8'h01;
    ev(ev_c);
    ev(ev_b);
    rsrc <= 1'b1;
    @(posedge clk_i);
    rsrc <= 1'b0;
    @(posedge clk_i);
    ck({ctl.reset_taken, ctl.stack_req, ctl.vector_sel, ctl.i_mask}, {2'b10, elp_pkg::VEC_RESET, 1'b1});
    dly <= 4'h1;
    rdck(elp_pkg::OFF_BREAK_CTRL, 32'h0);
    final_report;
  end
endmodule : tb
